// ==== dcc_bus_partner.sv ====
`timescale 1ns/100ps
module dcc_bus_partner (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic snoop_bus_request,
  input wire logic general_bus_request,
  input wire logic pause_en,
  output logic bus_grant,
  output logic bus_pause
);
  logic [1:0] wait_reg;
  // grant latency varies from one request to the next
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_reg <= 2'h0;
      bus_grant <= 1'b0;
      bus_pause <= 1'b0;
    end else begin
      bus_pause <= pause_en & ~bus_pause;
      if (!(snoop_bus_request | general_bus_request)) begin
        bus_grant <= 1'b0;
        wait_reg <= wait_reg + 2'h1;
      end else if (wait_reg == 2'h0) begin
        bus_grant <= 1'b1;
      end else begin
        wait_reg <= wait_reg - 2'h1;
      end
    end
  end
endmodule : dcc_bus_partner

// ==== dcc_channel.sv ====
`timescale 1ns/100ps
// Notes on behaviour
// R1 - level mode with external requests: sustained low request line means request
// R2 - edge mode: a falling edge of the request line is one request
// R3 - level/edge select ignored when software requests are chosen
// R4 - software sets level mode when the interrupt controller line is used
// R5 - snoop select issues snoop bus requests, else general bus requests
// R6 - release enabled and owning bus: core release request returns bus at pause
// R7 - release disabled: core release requests ignored, bus kept
// R8 - release enable only acts in general bus-request mode
// R9 - source type bit: one is peripheral, zero is memory
// R10 - source step: 1x fixed, 01 decrement, 00 increment
// R11 - destination type bit: one is peripheral, zero is memory
// R12 - destination step: 1x fixed, 01 decrement, 00 increment
// R13 - unit size: 11 one byte, 10 two bytes, 0x four bytes
// R14 - port width: 11 eight, 10 sixteen, 0x thirty-two bits
// R15 - software completes configuration before standby
// R16 - software keeps unit size and port width equal for peripheral transfers
// R17 - port width ignored in memory-to-memory transfers
// R18 - all control fields reset to zero
// R19 - request source mode: one external, zero software requests
// R20 - polarity zero: falling edge or low effective, acknowledge active low
// R21 - stepped addresses move by the unit size after each unit
module dcc_channel (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_dma_request_n,
  input wire logic intc_dma_request_n,
  output logic ext_dma_ack_n,
  output logic snoop_bus_request,
  output logic general_bus_request,
  input wire logic bus_grant,
  input wire logic core_release_request,
  input wire logic bus_pause,
  output logic [31:0] xfer_src_addr,
  output logic [31:0] xfer_dst_addr,
  output logic [2:0] xfer_bytes,
  output logic [5:0] port_bits,
  output logic src_is_peripheral,
  output logic dst_is_peripheral,
  input wire logic unit_done
);
  localparam int CW = dcc_pkg::CTRL_W;

  function automatic logic [2:0] size_bytes(input logic [1:0] code);
    unique case (code)
      2'b11: size_bytes = 3'h1;
      2'b10: size_bytes = 3'h2;
      default: size_bytes = 3'h4;
    endcase
  endfunction : size_bytes

  function automatic logic [31:0] step_addr(input logic [31:0] a, input logic [1:0] mode,
                                            input logic [2:0] n);
    if (mode[1]) begin
      step_addr = a;
    end else if (mode[0]) begin
      step_addr = a - {29'h0, n};
    end else begin
      step_addr = a + {29'h0, n};
    end
  endfunction : step_addr

  // request pins pass two flops before any use
  logic [1:0] extSync_reg, extSync_next;
  logic [1:0] intcSync_reg, intcSync_next;
  logic reqLast_reg, reqLast_next;
  logic [CW-1:0] ctrl_reg, ctrl_next;
  logic [31:0] src_reg, src_next, dst_reg, dst_next;
  logic pend_reg, pend_next;
  dcc_pkg::dcc_bus_t bus_reg, bus_next;
  logic awHeld_reg, awHeld_next, wHeld_reg, wHeld_next;
  logic [3:0] awAddr_reg, awAddr_next;
  logic [31:0] wData_reg, wData_next;
  logic [3:0] wStrb_reg, wStrb_next;
  logic bValid_reg, bValid_next;
  logic [1:0] bResp_reg, bResp_next;
  logic rValid_reg, rValid_next;
  logic [31:0] rData_reg, rData_next;
  logic [1:0] rResp_reg, rResp_next;

  logic reqLine, reqLevel, reqEdge, reqHit, extMode, levMode, snoopMode;
  logic [2:0] unitBytes;
  logic [31:0] wrMerged;
  logic [31:0] srcW, dstW;
  logic wrSrc, wrDst;

  always_comb begin
    extMode = ctrl_reg[dcc_pkg::EXR_BIT]; // R19
    levMode = ctrl_reg[dcc_pkg::LEV_BIT];
    snoopMode = ctrl_reg[dcc_pkg::SNOOP_BIT];
    // sel bit: 1 pin, 0 interrupt controller
    reqLine = ctrl_reg[dcc_pkg::SEL_BIT] ? extSync_reg[1] : intcSync_reg[1];
    reqLevel = ~reqLine; // R20
    reqEdge = reqLast_reg & ~reqLine; // R2
    // level/edge only matters in external mode
    reqHit = extMode & (levMode ? reqLevel : reqEdge); // R1 R3
    unitBytes = size_bytes(ctrl_reg[dcc_pkg::SIZ_LSB +: 2]); // R13
  end

  always_comb begin
    extSync_next = {extSync_reg[0], ext_dma_request_n};
    intcSync_next = {intcSync_reg[0], intc_dma_request_n};
    reqLast_next = reqLine;
    pend_next = pend_reg;
    bus_next = bus_reg;
    src_next = src_reg;
    dst_next = dst_reg;
    // edge and level requests are both latched; pending reloads from the request at unit end
    if (reqHit) begin
      pend_next = 1'b1;
    end
    unique case (bus_reg)
      dcc_pkg::DCC_IDLE: begin
        if (pend_reg && bus_grant) begin
          bus_next = dcc_pkg::DCC_OWN;
        end
      end
      dcc_pkg::DCC_OWN: begin
        if (unit_done) begin
          src_next = step_addr(src_reg, ctrl_reg[dcc_pkg::SAC_LSB +: 2], unitBytes); // R10 R21
          dst_next = step_addr(dst_reg, ctrl_reg[dcc_pkg::DAC_LSB +: 2], unitBytes); // R12 R21
          // a fresh edge in the closing cycle must not be lost: set wins over clear
          pend_next = reqHit; // R2
          bus_next = dcc_pkg::DCC_IDLE;
        end else if (!snoopMode && ctrl_reg[dcc_pkg::REL_BIT] && core_release_request) begin
          bus_next = dcc_pkg::DCC_REL; // R6 R7 R8
        end
      end
      dcc_pkg::DCC_REL: begin
        if (bus_pause) begin
          bus_next = dcc_pkg::DCC_IDLE; // R6
        end
      end
      default: bus_next = dcc_pkg::DCC_IDLE;
    endcase
    // software start: internal mode requests on a source pointer write, dropped when the unit ends
    if (!extMode) begin
      pend_next = pend_next & ~(bus_reg == dcc_pkg::DCC_OWN && unit_done);
    end
    // a software write to a pointer wins over the step of the same cycle
    if (wrSrc) begin
      src_next = srcW;
      // a software write to the source pointer starts an internal transfer
      pend_next = pend_next | ~extMode; // R3
    end
    if (wrDst) begin
      dst_next = dstW;
    end
  end

  always_comb begin
    awHeld_next = awHeld_reg;
    wHeld_next = wHeld_reg;
    awAddr_next = awAddr_reg;
    wData_next = wData_reg;
    wStrb_next = wStrb_reg;
    bValid_next = bValid_reg;
    bResp_next = bResp_reg;
    rValid_next = rValid_reg;
    rData_next = rData_reg;
    rResp_next = rResp_reg;
    ctrl_next = ctrl_reg;
    wrMerged = 32'h0;
    if (s_axi_awvalid && s_axi_awready) begin
      awHeld_next = 1'b1;
      awAddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wHeld_next = 1'b1;
      wData_next = s_axi_wdata;
      wStrb_next = s_axi_wstrb;
    end
    if (bValid_reg && s_axi_bready) begin
      bValid_next = 1'b0;
    end
    if (awHeld_reg && wHeld_reg && !bValid_reg) begin
      awHeld_next = 1'b0;
      wHeld_next = 1'b0;
      bValid_next = 1'b1;
      bResp_next = dcc_pkg::RESP_OKAY;
      unique case ({awAddr_reg[3:2], 2'b00})
        dcc_pkg::CTRL_OFS: begin
          for (int i = 0; i < 2; i++) begin
            if (wStrb_reg[i]) begin
              wrMerged[8*i +: 8] = wData_reg[8*i +: 8];
            end else begin
              wrMerged[8*i +: 8] = ctrl_reg[8*i +: 8];
            end
          end
          // polarity stays zero: the one setting is prohibited
          ctrl_next = wrMerged[CW-1:0] & dcc_pkg::CTRL_WMASK; // R20
        end
        dcc_pkg::SRC_OFS, dcc_pkg::DST_OFS: begin
        end
        default: bResp_next = dcc_pkg::RESP_SLVERR;
      endcase
    end
    if (rValid_reg && s_axi_rready) begin
      rValid_next = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rValid_next = 1'b1;
      rResp_next = dcc_pkg::RESP_OKAY;
      unique case ({s_axi_araddr[3:2], 2'b00})
        dcc_pkg::CTRL_OFS: rData_next = {16'h0, ctrl_reg};
        dcc_pkg::SRC_OFS: rData_next = src_reg;
        dcc_pkg::DST_OFS: rData_next = dst_reg;
        default: rData_next = {29'h0, pend_reg, bus_reg};
      endcase
    end
  end

  // address writes merge bytes into the running pointers
  always_comb begin
    wrSrc = awHeld_reg && wHeld_reg && !bValid_reg && awAddr_reg[3:2] == dcc_pkg::SRC_OFS[3:2];
    wrDst = awHeld_reg && wHeld_reg && !bValid_reg && awAddr_reg[3:2] == dcc_pkg::DST_OFS[3:2];
    for (int i = 0; i < 4; i++) begin
      srcW[8*i +: 8] = wStrb_reg[i] ? wData_reg[8*i +: 8] : src_reg[8*i +: 8];
      dstW[8*i +: 8] = wStrb_reg[i] ? wData_reg[8*i +: 8] : dst_reg[8*i +: 8];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      extSync_reg <= 2'h3;
      intcSync_reg <= 2'h3;
      reqLast_reg <= 1'b1;
      ctrl_reg <= dcc_pkg::CTRL_RST; // R18
      src_reg <= dcc_pkg::ADDR_RST;
      dst_reg <= dcc_pkg::ADDR_RST;
      pend_reg <= 1'b0;
      bus_reg <= dcc_pkg::DCC_IDLE;
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= 4'h0;
      wData_reg <= 32'h0;
      wStrb_reg <= 4'h0;
      bValid_reg <= 1'b0;
      bResp_reg <= 2'h0;
      rValid_reg <= 1'b0;
      rData_reg <= 32'h0;
      rResp_reg <= 2'h0;
    end else begin
      extSync_reg <= extSync_next;
      intcSync_reg <= intcSync_next;
      reqLast_reg <= reqLast_next;
      ctrl_reg <= ctrl_next;
      src_reg <= src_next;
      dst_reg <= dst_next;
      pend_reg <= pend_next;
      bus_reg <= bus_next;
      awHeld_reg <= awHeld_next;
      wHeld_reg <= wHeld_next;
      awAddr_reg <= awAddr_next;
      wData_reg <= wData_next;
      wStrb_reg <= wStrb_next;
      bValid_reg <= bValid_next;
      bResp_reg <= bResp_next;
      rValid_reg <= rValid_next;
      rData_reg <= rData_next;
      rResp_reg <= rResp_next;
    end
  end

  always_comb begin
    s_axi_awready = !awHeld_reg;
    s_axi_wready = !wHeld_reg;
    s_axi_bvalid = bValid_reg;
    s_axi_bresp = bResp_reg;
    s_axi_arready = !rValid_reg;
    s_axi_rvalid = rValid_reg;
    s_axi_rdata = rData_reg;
    s_axi_rresp = rResp_reg;
    // bus request kind follows snoop select while a request waits or bus is held
    snoop_bus_request = snoopMode & (pend_reg | bus_reg != dcc_pkg::DCC_IDLE); // R5
    general_bus_request = !snoopMode & (pend_reg | bus_reg == dcc_pkg::DCC_OWN); // R5
    ext_dma_ack_n = !(extMode && bus_reg == dcc_pkg::DCC_OWN); // R20
    xfer_src_addr = src_reg;
    xfer_dst_addr = dst_reg;
    xfer_bytes = unitBytes;
    src_is_peripheral = ctrl_reg[dcc_pkg::SIO_BIT]; // R9
    dst_is_peripheral = ctrl_reg[dcc_pkg::DIO_BIT]; // R11
    // port width only meaningful when a peripheral end exists
    if (!(ctrl_reg[dcc_pkg::SIO_BIT] | ctrl_reg[dcc_pkg::DIO_BIT])) begin
      port_bits = 6'h0; // R17
    end else begin
      port_bits = {size_bytes(ctrl_reg[dcc_pkg::DPS_LSB +: 2]), 3'b000}; // R14
    end
  end
endmodule : dcc_channel

// ==== dcc_channel_assertions.sv ====
`timescale 1ns/100ps
module dcc_channel_assertions (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic ext_dma_ack_n,
  input wire logic snoop_bus_request,
  input wire logic general_bus_request,
  input wire logic bus_grant,
  input wire logic [31:0] xfer_src_addr,
  input wire logic [31:0] xfer_dst_addr,
  input wire logic [2:0] xfer_bytes,
  input wire logic [5:0] port_bits,
  input wire logic src_is_peripheral,
  input wire logic dst_is_peripheral,
  input wire logic unit_done
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  a_ack_owned: assert property (!ext_dma_ack_n |-> snoop_bus_request || general_bus_request)
    else $error("ack low without a bus request");
  a_one_request: assert property (!(snoop_bus_request && general_bus_request))
    else $error("snoop and general requests together");
  a_unit_bytes: assert property (xfer_bytes inside {3'h1, 3'h2, 3'h4})
    else $error("illegal unit size");
  a_port_width: assert property (src_is_peripheral || dst_is_peripheral |->
    port_bits inside {6'h8, 6'h10, 6'h20}) else $error("illegal port width");
  a_mem_port: assert property (!src_is_peripheral && !dst_is_peripheral |-> port_bits == 6'h0)
    else $error("port width used for memory transfer");
  // a write two cycles back may also reload the pointer, so those cycles are skipped
  a_step_size: assert property ($past(unit_done) && !$past(s_axi_wvalid) &&
    !$past(s_axi_wvalid, 2) && $changed(xfer_src_addr) |->
    (xfer_src_addr - $past(xfer_src_addr) == 32'(xfer_bytes)) ||
    ($past(xfer_src_addr) - xfer_src_addr == 32'(xfer_bytes))) else $error("bad step");
  a_dst_cause: assert property ($changed(xfer_dst_addr) |->
    $past(unit_done) || $past(s_axi_wvalid) || $past(s_axi_wvalid, 2))
    else $error("destination moved without cause");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  c_unit: cover property (unit_done);
  c_ack: cover property (!ext_dma_ack_n);
  c_snoop: cover property (snoop_bus_request && bus_grant);
endmodule : dcc_channel_assertions

// ==== dcc_pkg.sv ====
package dcc_pkg;
  // register byte offsets
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] SRC_OFS = 4'h4;
  localparam logic [3:0] DST_OFS = 4'h8;
  localparam logic [3:0] STAT_OFS = 4'hc;
  // channel_control field positions
  localparam int LEV_BIT = 12;
  localparam int SNOOP_BIT = 11;
  localparam int REL_BIT = 10;
  localparam int SIO_BIT = 9;
  localparam int SAC_LSB = 7;
  localparam int DIO_BIT = 6;
  localparam int DAC_LSB = 4;
  localparam int SIZ_LSB = 2;
  localparam int DPS_LSB = 0;
  localparam int EXR_BIT = 14;
  localparam int POL_BIT = 13;
  localparam int SEL_BIT = 15;
  localparam int CTRL_W = 16;
  localparam logic [CTRL_W-1:0] CTRL_RST = 16'h0000;
  localparam logic [CTRL_W-1:0] CTRL_WMASK = 16'hdfff;
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    DCC_IDLE = 2'b00,
    DCC_OWN = 2'b01,
    DCC_REL = 2'b10
  } dcc_bus_t;
endpackage : dcc_pkg

// ==== tb_dma_channel_control_config.sv ====
`timescale 1ns/100ps
module tb_dma_channel_control_config;
  logic core_clk, rst_b, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, xfer_src_addr, xfer_dst_addr, c, seed;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic ext_dma_request_n, intc_dma_request_n, ext_dma_ack_n, snoop_bus_request;
  logic general_bus_request, bus_grant, core_release_request, bus_pause, unit_done;
  logic src_is_peripheral, dst_is_peripheral, pause_en;
  logic [2:0] xfer_bytes;
  logic [5:0] port_bits;
  logic [31:0] expQ[$];
  int errors, checked;
  dcc_channel DUT (.*);
  dcc_bus_partner partner (.*);
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic report_and_stop;
    $display("counts: %0d checked, %0d errors", checked, errors);
    if (errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp
  always @(posedge core_clk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      cmp(s_axi_rdata, expQ.pop_front());
      cmp(s_axi_rresp, dcc_pkg::RESP_OKAY);
    end
  end
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    // only the status word refuses writes
    cmp(s_axi_bresp, a == dcc_pkg::STAT_OFS ? dcc_pkg::RESP_SLVERR : dcc_pkg::RESP_OKAY);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    expQ.push_back(e);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic own;
    int t;
    t = 0;
    do begin
      @(posedge core_clk);
      t++;
    end while (!bus_grant && t < 20);
    cmp(bus_grant, 1);
    @(posedge core_clk);
  endtask : own
  task automatic pulse;
    @(posedge core_clk);
    unit_done <= 1'b1;
    @(posedge core_clk);
    unit_done <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask : pulse
  task automatic xfer(input logic [31:0] cc, s, es, ed);
    wr(4'h0, cc);
    wr(4'h8, 32'h100);
    cmp(general_bus_request | snoop_bus_request, 0);
    wr(4'h4, s);
    own();
    cmp(snoop_bus_request, cc[11]);
    cmp(general_bus_request, !cc[11]);
    pulse();
    cmp(xfer_src_addr, es);
    cmp(xfer_dst_addr, ed);
  endtask : xfer
  initial begin
    seed = 32'h6a6bfe29;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {unit_done, core_release_request, pause_en, rst_b} = '0;
    s_axi_wstrb = 4'hf;
    ext_dma_request_n = 1'b1;
    intc_dma_request_n = 1'b1;
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(4'h0, 32'h0);
    cmp(xfer_bytes, 4);
    cmp(ext_dma_ack_n, 1);
    wr(4'hc, 32'h7);
    rd(4'hc, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      c = 32'h200 | (i << 2) | i;
      wr(4'h0, c);
      rd(4'h0, c);
      cmp(xfer_bytes, i == 3 ? 1 : i == 2 ? 2 : 4);
      cmp(port_bits, i == 3 ? 8 : i == 2 ? 16 : 32);
      cmp(src_is_peripheral, 1);
    end
    wr(4'h0, 32'h43);
    cmp(dst_is_peripheral, 1);
    cmp(src_is_peripheral, 0);
    wr(4'h0, 32'h3);
    cmp(port_bits, 0);
    repeat (4) begin
      c = $random(seed);
      wr(4'h0, c);
      rd(4'h0, c & 32'hdfff);
    end
    $display("test field codes done");
    // leave the random setting before the pin goes low, or it may raise a request
    wr(4'h0, 32'h0);
    ext_dma_request_n <= 1'b0;
    xfer(32'h1018, 32'h200, 32'h202, 32'hfe);
    xfer(32'h188c, 32'h300, 32'h2ff, 32'h101);
    xfer(32'h1928, 32'h300, 32'h300, 32'h100);
    $display("test internal transfers done");
    for (int i = 0; i < 3; i++) begin
      ext_dma_request_n <= 1'b1;
      wr(4'h0, i == 0 ? 32'hc400 : i == 1 ? 32'hc000 : 32'hcc00);
      ext_dma_request_n <= 1'b0;
      own();
      cmp(ext_dma_ack_n, 0);
      core_release_request <= 1'b1;
      // pending stays set until the unit is moved, so status shows it while owned or, with release enabled outside snoop mode, released
      rd(4'hc, i == 0 ? 32'h6 : 32'h5);
      core_release_request <= 1'b0;
      pause_en <= 1'b1;
      repeat (2) @(posedge core_clk);
      pause_en <= 1'b0;
      // a released unit is still pending, so the bus is won back before it ends
      own();
      pulse();
      rd(4'hc, 32'h0);
    end
    wr(4'h0, 32'hd000);
    own();
    cmp(ext_dma_ack_n, 0);
    pulse();
    own();
    cmp(general_bus_request, 1);
    wr(4'h0, 32'h5000);
    pulse();
    rd(4'hc, 32'h0);
    intc_dma_request_n <= 1'b0;
    own();
    cmp(ext_dma_ack_n, 0);
    cmp(general_bus_request, 1);
    intc_dma_request_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    pulse();
    rd(4'hc, 32'h0);
    $display("test external requests done");
    report_and_stop();
  end
  initial begin
    #500000;
    errors++;
    report_and_stop();
  end
endmodule : tb_dma_channel_control_config
bind dcc_channel dcc_channel_assertions chk (.*);
